// file: hdl/ftb_sram.sv
// flow-through burst sram: cycle decode, burst counter, byte writes, output drive
// How it works
// - selected load edge with write strobe high latches address, starts read burst
// - advance edge during read burst steps address, fetches next data, ignores selects
// - read with output enable high still advances but leaves data bus undriven
// - selected load edge with write strobe low starts write burst, whatever the lane selects
// - advance edge during write burst steps address, takes lanes selected that cycle
// - write start with no lane selected still opens the burst: nothing written, bus undriven
// - write continuation with no lane selected advances address, changes no byte
// - edge with clock gate high is ignored; address holds, operation holds unless asleep
// - wide build: four lane selects, any mix legal, only selected lanes written
// - narrow build: two lane selects, none selected writes nothing, both writes both
// - any write cycle keeps every data and parity pin undriven
// - output enable is combinational and masked off during write cycles
// - read data driven only while output enable low in a read burst opened by a selected load
// - after power-up device is deselected with pins undriven whatever output enable
// - write strobe high decodes a read regardless of lane selects
// - sleep request puts device asleep within a few cycles; controller deselects first
// - burst order input picks linear wrap or interleaved order on low address bits
// - write data is taken at the edge after the address edge
// - one loaded address serves a burst of four accesses, then wraps
`timescale 1ns/1ns
`default_nettype none

module ftb_sram
  import ftb_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int LANES = 4
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_second_high,
  input wire logic chip_select_tertiary_n,
  input wire logic burst_step_or_load,
  input wire logic write_enable_n,
  input wire logic [LANES-1:0] byte_lane_select_n,
  input wire logic output_enable_n,
  input wire logic clock_gate_n,
  input wire logic sleep_request,
  input wire logic burst_order_interleaved,
  input wire logic [LANES*FTB_LANE_BITS-1:0] data_in,
  output logic [LANES*FTB_LANE_BITS-1:0] data_out,
  output logic data_oe,
  input wire logic [LANES-1:0] parity_lanes_in,
  output logic [LANES-1:0] parity_lanes_out,
  output logic parity_lanes_oe,
  output logic sleep_active
);

  localparam int DW = LANES * FTB_LANE_BITS;
  localparam int WW = DW + LANES;
  localparam int DEPTH = 2 ** ADDR_W;

  // storage: data lanes in the low bits, parity lanes above them
  logic [WW-1:0] mem [DEPTH];

  logic sleep_s1_ff;
  logic sleep_s2_ff;
  logic sleep_s3_ff;
  logic sleep_ff;
  ftb_op_t op_ff;
  ftb_op_t nxt_op;
  logic [ADDR_W-1:0] base_ff;
  logic [1:0] cnt_ff;
  logic order_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic load;
  logic selected;
  logic wr_pend_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [LANES-1:0] wr_lanes_ff;
  logic [WW-1:0] wr_word;
  logic [WW-1:0] rd_word;
  logic [WW-1:0] rd_data_ff;
  logic drive_read;

  // low burst address bits for a given step in the chosen order
  function automatic logic [1:0] burst_low(input logic [1:0] first,
                                           input logic [1:0] step,
                                           input logic interleaved);
    logic [1:0] res;
    res = 2'h0;
    if (interleaved)
    begin
      res = first ^ step;
    end
    else
    begin
      res = 2'(first + step);
    end
    return res;
  endfunction

  // lay the incoming lanes over an old word, keeping lanes not selected
  function automatic logic [WW-1:0] merge_lanes(input logic [WW-1:0] old,
                                                input logic [DW-1:0] din,
                                                input logic [LANES-1:0] pin,
                                                input logic [LANES-1:0] lanes);
    logic [WW-1:0] res;
    res = old;
    for (int l = 0; l < LANES; l++)
    begin
      if (lanes[l])
      begin
        res[l*FTB_LANE_BITS +: FTB_LANE_BITS] = din[l*FTB_LANE_BITS +: FTB_LANE_BITS];
        res[DW + l] = pin[l];
      end
    end
    return res;
  endfunction

  // sleep request is asynchronous: three stages, counted once the last two agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sleep_s1_ff <= FTB_SLEEP_RST;
      sleep_s2_ff <= FTB_SLEEP_RST;
      sleep_s3_ff <= FTB_SLEEP_RST;
    end
    else
    begin
      sleep_s1_ff <= sleep_request;
      sleep_s2_ff <= sleep_s1_ff;
      sleep_s3_ff <= sleep_s2_ff;
    end
  end

  // sleep state follows the agreed level; the clock gate does not stall it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sleep_ff <= FTB_SLEEP_RST;
    end
    else if (sleep_s2_ff == sleep_s3_ff)
    begin
      sleep_ff <= sleep_s3_ff;
    end
  end

  assign sleep_active = sleep_ff;

  // load versus advance, and the three-way chip select
  assign load = !burst_step_or_load;
  assign selected = !chip_select_primary_n && chip_select_second_high &&
                    !chip_select_tertiary_n;

  // operation decode for the coming cycle
  always_comb
  begin
    nxt_op = op_ff;
    if (sleep_ff)
    begin
      nxt_op = FTB_OP_DESEL;
    end
    else if (load)
    begin
      if (!selected)
      begin
        nxt_op = FTB_OP_DESEL;
      end
      else if (write_enable_n)
      begin
        nxt_op = FTB_OP_READ;
      end
      else
      begin
        nxt_op = FTB_OP_WRITE;
      end
    end
    else
    begin
      nxt_op = op_ff;
    end
  end

  // address for the coming cycle: external on load, next burst step otherwise
  always_comb
  begin
    if (load)
    begin
      nxt_addr = address;
    end
    else
    begin
      nxt_addr = {base_ff[ADDR_W-1:FTB_BURST_LOW_BITS],
                  burst_low(base_ff[1:0], 2'(cnt_ff + FTB_BURST_STEP), order_ff)};
    end
  end

  // operation register; a gated edge holds it except while asleep
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      op_ff <= FTB_OP_DESEL;
    end
    else if (!clock_gate_n || sleep_ff)
    begin
      op_ff <= nxt_op;
    end
  end

  // burst counter: base captured on load, two-bit step wraps after four
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      base_ff <= '0;
      cnt_ff <= FTB_BURST_FIRST;
      order_ff <= FTB_ORDER_RST;
    end
    else if (!clock_gate_n && !sleep_ff)
    begin
      if (load && selected)
      begin
        base_ff <= address;
        cnt_ff <= FTB_BURST_FIRST;
        order_ff <= burst_order_interleaved;
      end
      else if (!load && op_ff != FTB_OP_DESEL)
      begin
        cnt_ff <= 2'(cnt_ff + FTB_BURST_STEP);
      end
    end
  end

  // pending write beat: address and lanes now, data at the following edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_ff <= FTB_PEND_RST;
      wr_addr_ff <= '0;
      wr_lanes_ff <= '0;
    end
    else if (sleep_ff)
    begin
      wr_pend_ff <= FTB_PEND_RST;
    end
    else if (!clock_gate_n)
    begin
      wr_pend_ff <= (nxt_op == FTB_OP_WRITE) && (|(~byte_lane_select_n));
      wr_addr_ff <= nxt_addr;
      wr_lanes_ff <= ~byte_lane_select_n;
    end
  end

  // word as it stands once the pending beat lands
  assign wr_word = merge_lanes(mem[wr_addr_ff], data_in, parity_lanes_in, wr_lanes_ff);

  // commit the write data at the edge after the address edge
  always_ff @(posedge clock)
  begin
    if (wr_pend_ff && !clock_gate_n && !sleep_ff)
    begin
      mem[wr_addr_ff] <= wr_word;
    end
  end

  // read fetch, forwarding a write that lands on the same edge and address
  always_comb
  begin
    rd_word = mem[nxt_addr];
    if (wr_pend_ff && wr_addr_ff == nxt_addr)
    begin
      rd_word = wr_word;
    end
  end

  // read data is captured at the address edge, so it is ready this cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rd_data_ff <= '0;
    end
    else if (!clock_gate_n && !sleep_ff && nxt_op == FTB_OP_READ)
    begin
      rd_data_ff <= rd_word;
    end
  end

  assign data_out = rd_data_ff[DW-1:0];
  assign parity_lanes_out = rd_data_ff[WW-1:DW];

  // drivers on only for a read, never in a write, deselect or sleep
  assign drive_read = (op_ff == FTB_OP_READ) && !sleep_ff;

  // output enable acts without the clock and is masked outside reads
  assign data_oe = drive_read && !output_enable_n;
  assign parity_lanes_oe = drive_read && !output_enable_n;

endmodule // ftb_sram

`default_nettype wire

// file: hdl/ftb_pkg.sv
// shared constants and types for the flow-through burst sram cycle decode
package ftb_pkg;

  // operation held between clock edges
  typedef enum logic [1:0] {
    FTB_OP_DESEL,
    FTB_OP_READ,
    FTB_OP_WRITE
  } ftb_op_t;

  // clock rate and figures derived from it
  localparam int FTB_CLK_PERIOD_NS = 4;
  localparam int FTB_SLEEP_CYCLES = 2;

  // layout of one lane (a data byte plus one parity bit) and the burst counter figures
  localparam int FTB_LANE_BITS = 8;
  localparam int FTB_BURST_LOW_BITS = 2;
  localparam logic [1:0] FTB_BURST_FIRST = 2'h0;
  localparam logic [1:0] FTB_BURST_STEP = 2'h1;

  // values after reset
  localparam logic FTB_SLEEP_RST = 1'b0;
  localparam logic FTB_ORDER_RST = 1'b0;
  localparam logic FTB_PEND_RST = 1'b0;

endpackage : ftb_pkg

// file: verif/ftb_sram_properties.sv
// checker for drive enables, stall and sleep of the sram cycle decode
`timescale 1ns/1ns
`default_nettype none

module ftb_sram_properties
  import ftb_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int LANES = 4
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_second_high,
  input wire logic chip_select_tertiary_n,
  input wire logic burst_step_or_load,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic clock_gate_n,
  input wire logic sleep_request,
  input wire logic [LANES*FTB_LANE_BITS-1:0] data_out,
  input wire logic data_oe,
  input wire logic parity_lanes_oe,
  input wire logic sleep_active
);
  // load edge and full selection as the device decodes them
  wire ld = !clock_gate_n && !burst_step_or_load && !sleep_active;
  wire sel = !chip_select_primary_n && chip_select_second_high && !chip_select_tertiary_n;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_write_no_drive: assert property (
    ld && sel && !write_enable_n |=> !data_oe) else $error("pins driven in write");
  a_read_drive: assert property (
    ld && sel && write_enable_n |=> data_oe == !output_enable_n) else $error("read drive");
  a_desel_quiet: assert property (
    ld && !sel |=> !data_oe) else $error("pins driven when deselected");
  a_stall_hold: assert property (
    clock_gate_n |=> $stable(data_out)) else $error("stalled edge changed data");
  a_oe_mask: assert property (
    output_enable_n |-> !data_oe) else $error("drive with output enable off");
  a_lane_oe_pair: assert property (
    parity_lanes_oe == data_oe) else $error("parity enable differs");
  a_reset_quiet: assert property (
    $fell(rst) |-> !data_oe && !sleep_active) else $error("not quiet after reset");
  a_sleep_entry: assert property (
    $rose(sleep_request) |-> ##[1:6] sleep_active) else $error("sleep not entered");
  a_sleep_quiet: assert property (
    sleep_active |-> !data_oe) else $error("pins driven in sleep");
endmodule // ftb_sram_properties

bind ftb_sram ftb_sram_properties #(.ADDR_W(ADDR_W), .LANES(LANES)) u_props (.*);

`default_nettype wire

// file: verif/ftb_ctrl_model.sv
// memory controller model: puts write beats on the data pins
`timescale 1ns/1ns
`default_nettype none

module ftb_ctrl_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] cs,
  input wire logic burst_step_or_load,
  input wire logic write_enable_n,
  input wire logic clock_gate_n,
  input wire logic [31:0] payload,
  output logic [31:0] data_in,
  output logic [3:0] parity_lanes_in
);
  logic wr_phase_ff;

  // track whether the bus is in the data part of a write burst
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wr_phase_ff <= 1'b0;
    else if (!clock_gate_n && !burst_step_or_load)
      wr_phase_ff <= (cs == 3'h2) && !write_enable_n;
  end

  // beat data while writing, inverted pattern while the bus is not ours
  assign data_in = wr_phase_ff ? payload : ~payload;
  assign parity_lanes_in = {^data_in[31:24], ^data_in[23:16], ^data_in[15:8], ^data_in[7:0]};
endmodule // ftb_ctrl_model

`default_nettype wire

// file: verif/ftb_sram_tb.sv
// self-checking bench for the flow-through burst sram decode
`timescale 1ns/1ns
`default_nettype none

module ftb_sram_tb;
  typedef struct packed {
    logic [2:0] cs;
    logic [4:0] c;
    logic [3:0] be;
    logic [7:0] a;
    logic [31:0] wd;
    logic eo;
    logic [31:0] ed;
  } ftb_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] cs;
  logic adv, we_n, cg_n, ord, oe_n, slp, doe, poe, sa;
  logic [3:0] be, pin, pout;
  logic [7:0] address;
  logic [31:0] pay, din, dout;
  int n_mismatch = 0;
  int samples_checked = 0;
  ftb_row_t rows [21];

  ftb_sram #(.ADDR_W(8), .LANES(4)) dut (
    .clock(clock), .rst(rst), .address(address),
    .chip_select_primary_n(cs[2]), .chip_select_second_high(cs[1]),
    .chip_select_tertiary_n(cs[0]), .burst_step_or_load(adv), .write_enable_n(we_n),
    .byte_lane_select_n(be), .output_enable_n(oe_n), .clock_gate_n(cg_n),
    .sleep_request(slp), .burst_order_interleaved(ord), .data_in(din), .data_out(dout),
    .data_oe(doe), .parity_lanes_in(pin), .parity_lanes_out(pout),
    .parity_lanes_oe(poe), .sleep_active(sa));

  ftb_ctrl_model u_ctrl (.clock(clock), .rst(rst), .cs(cs), .burst_step_or_load(adv),
    .write_enable_n(we_n), .clock_gate_n(cg_n), .payload(pay), .data_in(din),
    .parity_lanes_in(pin));

  // free-running device clock
  always #2 clock = ~clock;

  function automatic logic [3:0] par(input logic [31:0] d);
    par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // rows: selects, {step,we_n,gate_n,order,oe_n}, lanes_n, address, beat, drive, read data
  initial
  begin
    int i;
    {cs, adv, we_n, cg_n, ord, oe_n, be, address, pay, slp} = {3'h5, 5'h08, 4'hF, 8'h0, 33'h0};
    rows = '{'{3'h2, 5'h00, 4'h0, 8'h08, 32'h0, 1'h0, 32'h0},
      '{3'h5, 5'h18, 4'h0, 8'h00, 32'h11111111, 1'h0, 32'h0},
      '{3'h5, 5'h18, 4'h0, 8'h00, 32'h2A2A2A2A, 1'h0, 32'h0},
      '{3'h5, 5'h18, 4'h0, 8'h00, 32'h33333333, 1'h0, 32'h0},
      '{3'h2, 5'h00, 4'hA, 8'h09, 32'h44444444, 1'h0, 32'h0},
      '{3'h5, 5'h18, 4'hF, 8'h00, 32'h55555555, 1'h0, 32'h0},
      '{3'h2, 5'h0A, 4'h0, 8'h09, 32'h66666666, 1'h1, 32'h2A552A55},
      '{3'h5, 5'h12, 4'h0, 8'h00, 32'h0, 1'h1, 32'h11111111},
      '{3'h5, 5'h13, 4'h0, 8'h00, 32'h0, 1'h0, 32'h0},
      '{3'h5, 5'h12, 4'h0, 8'h00, 32'h0, 1'h1, 32'h33333333},
      '{3'h2, 5'h06, 4'h0, 8'h00, 32'h0, 1'h1, 32'h33333333},
      '{3'h2, 5'h08, 4'h0, 8'h0B, 32'h0, 1'h1, 32'h44444444},
      '{3'h5, 5'h18, 4'h0, 8'h00, 32'h0, 1'h1, 32'h11111111},
      '{3'h2, 5'h00, 4'hF, 8'h08, 32'h0, 1'h0, 32'h0},
      '{3'h5, 5'h18, 4'hF, 8'h00, 32'h77777777, 1'h0, 32'h0},
      '{3'h2, 5'h08, 4'h0, 8'h08, 32'h0, 1'h1, 32'h11111111},
      '{3'h5, 5'h18, 4'h0, 8'h00, 32'h0, 1'h1, 32'h2A552A55},
      '{3'h6, 5'h08, 4'h0, 8'h00, 32'h0, 1'h0, 32'h0},
      '{3'h5, 5'h18, 4'h0, 8'h00, 32'h0, 1'h0, 32'h0},
      '{3'h0, 5'h08, 4'h0, 8'h00, 32'h0, 1'h0, 32'h0},
      '{3'h3, 5'h08, 4'h0, 8'h00, 32'h0, 1'h0, 32'h0}};
    repeat (6) @(negedge clock);
    chk(doe, 32'h0);
    chk(poe, 32'h0);
    rst = 1'b0;
    $display("reset test done");
    for (int r = 0; r <= 21; r++)
    begin
      @(negedge clock);
      if (r > 0)
      begin
        chk(doe, rows[r-1].eo);
        chk(poe, rows[r-1].eo);
        if (rows[r-1].eo)
        begin
          chk(dout, rows[r-1].ed);
          chk(pout, par(rows[r-1].ed));
        end
      end
      if (r < 21)
        {cs, adv, we_n, cg_n, ord, oe_n, be, address, pay} = rows[r][84:33];
    end
    $display("table test done");
    slp = 1'b1;
    adv = 1'b1;
    for (i = 0; i < 8 && sa !== 1'b1; i++) @(negedge clock);
    chk(sa, 32'h1);
    chk(doe, 32'h0);
    slp = 1'b0;
    for (i = 0; i < 8 && sa !== 1'b0; i++) @(negedge clock);
    chk(sa, 32'h0);
    repeat (2) @(negedge clock);
    {cs, adv, we_n, address} = {3'h2, 1'h0, 1'h1, 8'h08};
    @(negedge clock);
    chk(dout, 32'h11111111);
    $display("sleep test done");
    close_out();
  end
endmodule // ftb_sram_tb

`default_nettype wire
